/* File: verilog/mem_map_pkg.sv */
`default_nettype none
package mem_map_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0]  LEGACY_CTRL_OFFSET = 8'h97;
  localparam logic [7:0]  LEGACY_CTRL_RESET  = 8'h00;
  localparam int          HOLE_EN_BIT        = 7;

  // ==========================================================
  // Address map in 1 MB units (address bits 31:20, zero extended)
  localparam int          MB_W       = 13;
  localparam logic [12:0] HOLE_MB    = 13'h00F;
  localparam logic [12:0] TOP_4G_MB  = 13'h1000;
  localparam logic [12:0] TOP_2G_MB  = 13'h0800;
  localparam logic [12:0] USABLE_RST = 13'h0000;

  // ==========================================================
  // Reserved-area size codes
  localparam logic [1:0]  SEG_1MB  = 2'h0;
  localparam logic [1:0]  SEG_2MB  = 2'h1;
  localparam logic [1:0]  SEG_8MB  = 2'h2;
  localparam logic [2:0]  GFX_1MB  = 3'h1;
  localparam logic [2:0]  GFX_4MB  = 3'h2;
  localparam logic [2:0]  GFX_8MB  = 3'h3;
  localparam logic [2:0]  GFX_16MB = 3'h4;
  localparam logic [2:0]  GFX_32MB = 3'h5;
  localparam logic [2:0]  GFX_64MB = 3'h6;

  // ==========================================================
  // Exception window slots
  localparam int WIN_EGRESS   = 0;
  localparam int WIN_CTRL     = 1;
  localparam int WIN_LINKREG  = 2;
  localparam int WIN_PCIE_CFG = 3;
  localparam int WIN_APER     = 4;
  localparam int WIN_GTT      = 5;
  localparam int WIN_GREG0    = 6;
  localparam int WIN_GREG1    = 7;
  localparam int WIN_PCIE_MEM = 8;
  localparam int WIN_PCIE_PRE = 9;
  localparam int WIN_N        = 10;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    SRC_CPU, SRC_LINK, SRC_PCIE, SRC_GFX
  } source_t;

  typedef enum logic [2:0] {
    TGT_DRAM, TGT_LINK, TGT_PCIE, TGT_PCIE_CFG,
    TGT_GFX, TGT_INTERNAL, TGT_INVALID
  } target_t;

  typedef struct packed {
    logic        valid;
    source_t     src;
    logic        smm;
    logic        wb;
    logic        write;
    logic [7:0]  be;
    logic [31:0] addr;
  } request_t;

  typedef struct packed {
    logic        valid;
    target_t     tgt;
    logic        write;
    logic [7:0]  be;
    logic [31:0] addr;
    logic [7:0]  bus;
    logic [4:0]  dev;
    logic [2:0]  func;
  } route_t;

  typedef struct packed {
    logic        en;
    logic [31:0] base;
    logic [31:0] limit;
  } window_t;

  // ==========================================================
  // Size decoders
  function automatic logic [12:0] seg_mb(input logic [1:0] code);
    case (code)
      SEG_2MB: seg_mb = 13'h002;
      SEG_8MB: seg_mb = 13'h008;
      default: seg_mb = 13'h001;
    endcase
  endfunction

  function automatic logic [12:0] stolen_mb(input logic [2:0] code);
    case (code)
      GFX_1MB:  stolen_mb = 13'h001;
      GFX_4MB:  stolen_mb = 13'h004;
      GFX_8MB:  stolen_mb = 13'h008;
      GFX_16MB: stolen_mb = 13'h010;
      GFX_32MB: stolen_mb = 13'h020;
      GFX_64MB: stolen_mb = 13'h040;
      default:  stolen_mb = 13'h000;
    endcase
  endfunction

endpackage
`default_nettype wire

/* File: verilog/window_match.sv */
`timescale 1ns/1ps
`default_nettype none
module window_match #(
  parameter bit EXCLUSIVE = 1'b0
) (
  // Address and window
  input  wire logic [31:0]          addr_in,
  input  wire mem_map_pkg::window_t win_in,
  // Result
  output logic                      hit_out
);
  import mem_map_pkg::*;

  // Base/limit compare, open or closed interval
  always_comb begin
    if (EXCLUSIVE) begin
      hit_out = win_in.en && (addr_in > win_in.base)
                && (addr_in < win_in.limit);
    end else begin
      hit_out = win_in.en && (addr_in >= win_in.base)
                && (addr_in <= win_in.limit);
    end
  end

endmodule // window_match
`default_nettype wire

/* File: verilog/region_bounds.sv */
`timescale 1ns/1ps
`default_nettype none
module region_bounds (
  // Configuration
  input  wire logic [12:0] top_usable_mb_in,
  input  wire logic        gfx_en_in,
  input  wire logic [2:0]  gfx_size_in,
  input  wire logic        top_seg_en_in,
  input  wire logic [1:0]  top_seg_size_in,
  // Derived bounds in MB
  output logic [12:0]      stolen_base_out,
  output logic [12:0]      seg_base_out
);
  import mem_map_pkg::*;

  logic [12:0] stolen_sz;
  logic [12:0] seg_sz;

  // Graphics area at the top, protected segment right below it
  always_comb begin
    stolen_sz       = gfx_en_in ? stolen_mb(gfx_size_in) : 13'h000;
    seg_sz          = top_seg_en_in ? seg_mb(top_seg_size_in) : 13'h000;
    stolen_base_out = top_usable_mb_in - stolen_sz;
    seg_base_out    = stolen_base_out - seg_sz;
  end

endmodule // region_bounds
`default_nettype wire

/* File: verilog/memory_hole_smram_decode.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// (RULE1) Hole bit opens 15-16 MB hole
// (RULE2) Hole accesses go to south-bridge link
// (RULE3) DRAM behind hole is never relocated
// (RULE4) Protected segment 1/2/8 MB below graphics
// (RULE5) SMM processor access reaches same DRAM address
// (RULE6) Foreign hits become invalid, address zero
// (RULE7) Extended mode: non-SMM or non-WB invalid
// (RULE8) Non-SMM write-backs still complete to DRAM
// (RULE9) Usable memory excludes protected segment size
// (RULE10) Graphics area 1-64 MB, excluded from memory
// (RULE11) Software initialises reserved areas first
// (RULE12) Above usable DRAM defaults to link
// (RULE13) Internal register windows claimed internally
// (RULE14) PCIe memory windows route to PCIe; code sends the prefetchable window's own base and limit to link
// (RULE15) Config window routed by bus/dev/func
// (RULE16) Graphics windows route to internal graphics
// (RULE17) Software keeps windows off fixed areas
// (RULE18) Windows win over default link route
module memory_hole_smram_decode #(
  parameter logic [12:0] ADDR_TOP_MB = mem_map_pkg::TOP_4G_MB
) (
  // Clock and reset
  input  wire logic                 sys_clk_in,
  input  wire logic                 srst_in,
  // Configuration register port
  input  wire logic [7:0]           cfg_addr_in,
  input  wire logic                 cfg_wr_in,
  input  wire logic                 cfg_rd_in,
  input  wire logic [7:0]           cfg_wdata_in,
  output logic [7:0]                cfg_rdata_out,
  // Memory map configuration
  input  wire logic [12:0]          top_usable_mb_in,
  input  wire logic                 top_seg_en_in,
  input  wire logic [1:0]           top_seg_size_in,
  input  wire logic                 ext_smram_en_in,
  input  wire logic                 gfx_en_in,
  input  wire logic [2:0]           gfx_size_in,
  input  wire logic                 pcie_mem_en_in,
  input  wire mem_map_pkg::window_t [mem_map_pkg::WIN_N-1:0] win_in,
  // Request and decoded route
  input  wire mem_map_pkg::request_t req_in,
  output mem_map_pkg::route_t       route_out,
  output logic [12:0]               usable_mb_out
);
  import mem_map_pkg::*;

  // ==========================================================
  // Declarations
  logic [7:0]       legacy_access_control_ff;
  logic [7:0]       nxt_legacy_access_control;
  logic [7:0]       rdata_ff;
  logic [7:0]       nxt_rdata;
  route_t           route_ff;
  route_t           nxt_route;
  logic [12:0]      usable_ff;
  logic [12:0]      nxt_usable;
  logic [12:0]      stolen_base;
  logic [12:0]      seg_base;
  logic [WIN_N-1:0] hit;
  logic [12:0]      mb_c;
  logic             below_c;
  logic             hole_c;
  logic             in_seg_c;
  logic             in_stolen_c;
  logic             seg_pass_c;
  logic             bar_hit_c;
  logic             gfx_hit_c;
  logic             pcie_hit_c;

  // ==========================================================
  // Reserved area bounds
  region_bounds u_bounds (
    .top_usable_mb_in (top_usable_mb_in),
    .gfx_en_in        (gfx_en_in),
    .gfx_size_in      (gfx_size_in),
    .top_seg_en_in    (top_seg_en_in),
    .top_seg_size_in  (top_seg_size_in),
    .stolen_base_out  (stolen_base),
    .seg_base_out     (seg_base)
  );

  // ==========================================================
  // Exception windows; only the prefetchable one is an open interval, excluding base and limit
  for (genvar i = 0; i < WIN_N; i++) begin : g_win
    window_match #(
      .EXCLUSIVE (i == WIN_PCIE_PRE)
    ) u_match (
      .addr_in                (req_in.addr),
      .win_in                 (win_in[i]),
      .hit_out                (hit[i])
    );
  end

  // ==========================================================
  // Configuration register next state
  always_comb begin
    nxt_legacy_access_control = legacy_access_control_ff;
    nxt_rdata                 = 8'h00;
    if (cfg_wr_in && (cfg_addr_in == LEGACY_CTRL_OFFSET)) begin
      nxt_legacy_access_control = cfg_wdata_in;
    end
    if (cfg_rd_in && (cfg_addr_in == LEGACY_CTRL_OFFSET)) begin
      nxt_rdata = legacy_access_control_ff;
    end
  end

  // Configuration registers
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      legacy_access_control_ff <= LEGACY_CTRL_RESET;
      rdata_ff                 <= 8'h00;
    end else begin
      legacy_access_control_ff <= nxt_legacy_access_control;
      rdata_ff                 <= nxt_rdata;
    end
  end

  // ==========================================================
  // Region classification
  always_comb begin
    mb_c        = {1'b0, req_in.addr[31:20]};
    below_c     = mb_c < top_usable_mb_in;
    hole_c      = legacy_access_control_ff[HOLE_EN_BIT]
                  && (mb_c == HOLE_MB);                      // [RULE1]
    in_stolen_c = gfx_en_in && below_c
                  && (mb_c >= stolen_base);                  // [RULE10]
    in_seg_c    = top_seg_en_in && (mb_c >= seg_base)
                  && (mb_c < stolen_base);                   // [RULE4]
    // SMM access passes unless extended mode also needs WB
    seg_pass_c  = (req_in.smm && (req_in.wb || !ext_smram_en_in)) // [RULE7]
                  || (!req_in.smm && req_in.wb && req_in.write); // [RULE8]
    bar_hit_c   = hit[WIN_EGRESS] || hit[WIN_CTRL]
                  || hit[WIN_LINKREG];
    gfx_hit_c   = gfx_en_in && (hit[WIN_APER] || hit[WIN_GTT]
                  || hit[WIN_GREG0] || hit[WIN_GREG1]);
    pcie_hit_c  = pcie_mem_en_in
                  && (hit[WIN_PCIE_MEM] || hit[WIN_PCIE_PRE]);
  end

  // ==========================================================
  // Route decision
  always_comb begin
    nxt_route = '0;
    if (req_in.valid) begin
      nxt_route.valid = 1'b1;
      nxt_route.write = req_in.write;
      nxt_route.be    = req_in.be;
      nxt_route.addr  = req_in.addr;                 // [RULE3] [RULE5]
      if (below_c) begin
        if (hole_c) begin
          nxt_route.tgt = TGT_LINK;                  // [RULE2]
        end else if (in_seg_c) begin
          if (req_in.src != SRC_CPU) begin
            nxt_route.tgt = TGT_INVALID;             // [RULE6]
          end else if (seg_pass_c) begin
            nxt_route.tgt = TGT_DRAM;                // [RULE5] [RULE8]
          end else begin
            nxt_route.tgt = TGT_INVALID;             // [RULE7]
          end
        end else if (in_stolen_c) begin
          // Graphics area is reserved for the graphics engine
          nxt_route.tgt = (req_in.src == SRC_GFX) ? TGT_DRAM
                                                   : TGT_INVALID; // [RULE10]
        end else begin
          nxt_route.tgt = TGT_DRAM;
        end
      end else if (mb_c >= ADDR_TOP_MB) begin
        nxt_route.tgt = TGT_LINK;                    // [RULE12]
      end else if (bar_hit_c) begin
        nxt_route.tgt = TGT_INTERNAL;                // [RULE13] [RULE18]
      end else if (hit[WIN_PCIE_CFG]) begin
        nxt_route.tgt  = TGT_PCIE_CFG;               // [RULE15]
        nxt_route.bus  = req_in.addr[27:20];
        nxt_route.dev  = req_in.addr[19:15];
        nxt_route.func = req_in.addr[14:12];
      end else if (gfx_hit_c) begin
        nxt_route.tgt = TGT_GFX;                     // [RULE16]
      end else if (pcie_hit_c) begin
        nxt_route.tgt = TGT_PCIE;                    // [RULE14]
      end else begin
        nxt_route.tgt = TGT_LINK;                    // [RULE12] [RULE18]
      end
      // Invalid cycles go to location zero, writes lose all lanes
      if (nxt_route.tgt == TGT_INVALID) begin
        nxt_route.addr = 32'h0000_0000;              // [RULE6]
        if (req_in.write) begin
          nxt_route.be = 8'h00;                      // [RULE6]
        end
      end
    end
  end

  // Usable memory below the reserved areas
  always_comb begin
    nxt_usable = seg_base;                           // [RULE9] [RULE11]
  end

  // Route and size registers
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      route_ff  <= '0;
      usable_ff <= USABLE_RST;
    end else begin
      route_ff  <= nxt_route;
      usable_ff <= nxt_usable;
    end
  end

  // Registered outputs
  assign route_out     = route_ff;
  assign usable_mb_out = usable_ff;
  assign cfg_rdata_out = rdata_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (srst_in);

  sequence s_ctrl_write;
    cfg_wr_in && (cfg_addr_in == LEGACY_CTRL_OFFSET) && !cfg_rd_in;
  endsequence

  sequence s_ctrl_read;
    cfg_rd_in && (cfg_addr_in == LEGACY_CTRL_OFFSET) && !cfg_wr_in;
  endsequence

  a_ctrl_readback: assert property ( // [RULE1]
    s_ctrl_write ##1 s_ctrl_read |=> cfg_rdata_out == $past(cfg_wdata_in, 2))
    else $error("hole control register read back wrong");

  a_hole_to_link: assert property ( // [RULE2]
    req_in.valid && below_c && hole_c
    |=> route_out.valid && route_out.tgt == TGT_LINK
        && route_out.addr == $past(req_in.addr))
    else $error("open hole not sent to link");

  a_hole_closed_dram: assert property ( // [RULE1]
    req_in.valid && below_c && (mb_c == HOLE_MB)
    && !legacy_access_control_ff[HOLE_EN_BIT] && !in_seg_c && !in_stolen_c
    |=> route_out.tgt == TGT_DRAM)
    else $error("closed hole not decoded as memory");

  a_seg_smm_dram: assert property ( // [RULE5]
    req_in.valid && below_c && !hole_c && in_seg_c
    && req_in.src == SRC_CPU && req_in.smm
    && (req_in.wb || !ext_smram_en_in)
    |=> route_out.tgt == TGT_DRAM
        && route_out.addr == $past(req_in.addr))
    else $error("SMM access to segment remapped");

  a_foreign_smm_invalid: assert property ( // [RULE6]
    req_in.valid && below_c && !hole_c && in_seg_c
    && req_in.src != SRC_CPU
    |=> route_out.tgt == TGT_INVALID && route_out.addr == 32'h0
        && (!route_out.write || route_out.be == 8'h00))
    else $error("foreign segment access not invalidated");

  a_esmram_invalid: assert property ( // [RULE7]
    req_in.valid && below_c && !hole_c && in_seg_c
    && req_in.src == SRC_CPU && ext_smram_en_in
    && (req_in.smm ? !req_in.wb : !(req_in.wb && req_in.write))
    |=> route_out.tgt == TGT_INVALID)
    else $error("unprotected access reached segment");

  a_wb_coherent: assert property ( // [RULE8]
    req_in.valid && below_c && !hole_c && in_seg_c
    && req_in.src == SRC_CPU && !req_in.smm
    && req_in.wb && req_in.write
    |=> route_out.tgt == TGT_DRAM && route_out.be == $past(req_in.be))
    else $error("write-back to segment dropped");

  a_usable_size: assert property ( // [RULE9]
    top_seg_en_in && !gfx_en_in
    |=> usable_mb_out
        == 13'($past(top_usable_mb_in) - seg_mb($past(top_seg_size_in))))
    else $error("usable memory size wrong");

  a_bar_internal: assert property ( // [RULE13]
    req_in.valid && !below_c && (mb_c < ADDR_TOP_MB) && bar_hit_c
    |=> route_out.tgt == TGT_INTERNAL)
    else $error("register window forwarded");

  a_cfg_bdf: assert property ( // [RULE15]
    req_in.valid && !below_c && (mb_c < ADDR_TOP_MB) && !bar_hit_c
    && hit[WIN_PCIE_CFG]
    |=> route_out.tgt == TGT_PCIE_CFG
        && route_out.bus == $past(req_in.addr[27:20]))
    else $error("config window bus number wrong");

  a_default_link: assert property ( // [RULE12]
    req_in.valid && !below_c && !(|hit)
    |=> route_out.valid && route_out.tgt == TGT_LINK)
    else $error("unclaimed address not sent to link");

  a_idle_quiet: assert property (
    !req_in.valid |=> !route_out.valid)
    else $error("route without request");

endmodule // memory_hole_smram_decode
`default_nettype wire

/* File: verilog/placeholder_unused.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: verification/req_master.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Requester model for processor, link, PCIe and graphics masters
module req_master (
  // Clock
  input  wire logic                    clk_in,
  // Decoded answer and request
  input  wire mem_map_pkg::route_t     route_in,
  output var  mem_map_pkg::request_t   req_out
);
  import mem_map_pkg::*;
  // Idle bus carries no request
  initial req_out = '0;
  // One request per call, held across the taking edge
  task automatic send(input request_t r, output route_t rt);
    request_t idle;
    idle = ~r;
    idle.valid = 1'b0;
    @(negedge clk_in);
    req_out = r;
    @(posedge clk_in);
    @(negedge clk_in);
    rt = route_in;
    req_out = idle; // Released bus shows no stale value
  endtask
endmodule // req_master
`default_nettype wire

/* File: verification/memory_hole_smram_decode_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module memory_hole_smram_decode_bench;
  import mem_map_pkg::*;
  // ==========================================================
  // Stimulus and observed signals
  logic                sys_clk_in = 1'b0;
  logic                srst_in    = 1'b1;
  logic [7:0]          cfg_addr   = 8'h00;
  logic                cfg_wr     = 1'b0;
  logic                cfg_rd     = 1'b0;
  logic [7:0]          cfg_wdata  = 8'h00;
  logic [7:0]          cfg_rdata;
  logic [12:0]         top_mb     = 13'h0040;
  logic                seg_en     = 1'b0;
  logic [1:0]          seg_size   = 2'h0;
  logic                ext_en     = 1'b0;
  logic                gfx_en     = 1'b0;
  logic [2:0]          gfx_size   = 3'h0;
  logic                pcie_en    = 1'b0;
  window_t [WIN_N-1:0] win        = '0;
  request_t            req;
  route_t              route;
  route_t              rt;
  logic [12:0]         usable;
  logic [7:0]          rd;
  logic                wr_q       = 1'b0;
  int                  n_fail     = 0;
  int                  n_tests    = 0;
  // Clock at 20 MHz
  always #25 sys_clk_in = ~sys_clk_in;
  // Decoder, reduced variant top so the top boundary is reachable
  memory_hole_smram_decode #(.ADDR_TOP_MB(TOP_2G_MB)) i_memory_hole_smram_decode (
    .sys_clk_in      (sys_clk_in),
    .srst_in         (srst_in),
    .cfg_addr_in     (cfg_addr),
    .cfg_wr_in       (cfg_wr),
    .cfg_rd_in       (cfg_rd),
    .cfg_wdata_in    (cfg_wdata),
    .cfg_rdata_out   (cfg_rdata),
    .top_usable_mb_in (top_mb),
    .top_seg_en_in   (seg_en),
    .top_seg_size_in (seg_size),
    .ext_smram_en_in (ext_en),
    .gfx_en_in       (gfx_en),
    .gfx_size_in     (gfx_size),
    .pcie_mem_en_in  (pcie_en),
    .win_in          (win),
    .req_in          (req),
    .route_out       (route),
    .usable_mb_out   (usable)
  );
  // Requesters on the far side
  req_master i_req_master (.clk_in(sys_clk_in), .route_in(route), .req_out(req));
  // ==========================================================
  // Verdict and comparisons
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk_byte(input string nm, input logic [7:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_mb(input string nm, input logic [12:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_route(input string nm, input target_t et,
                           input logic [31:0] ea, input logic [7:0] eb);
    n_tests++;
    if (rt.valid !== 1'b1 || rt.tgt !== et || rt.addr !== ea || rt.be !== eb
        || rt.write !== wr_q) begin
      n_fail++;
      $display("mismatch %s expected %0d %h %h seen %0d %h %h", nm, et, ea,
               eb, rt.tgt, rt.addr, rt.be);
    end
  endtask
  // ==========================================================
  // Bus cycles
  task automatic cfg_write(input logic [7:0] a, d);
    @(negedge sys_clk_in);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(negedge sys_clk_in);
    cfg_wr = 1'b0;
  endtask
  task automatic cfg_read(input logic [7:0] a);
    @(negedge sys_clk_in);
    cfg_addr = a;
    cfg_rd = 1'b1;
    @(negedge sys_clk_in);
    cfg_rd = 1'b0;
    rd = cfg_rdata;
  endtask
  // Write, then read the same offset in the very next cycle
  task automatic cfg_write_read(input logic [7:0] a, d);
    @(negedge sys_clk_in);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(negedge sys_clk_in);
    cfg_wr = 1'b0;
    cfg_rd = 1'b1;
    @(negedge sys_clk_in);
    cfg_rd = 1'b0;
    rd = cfg_rdata;
  endtask
  task automatic go(input source_t s, input logic smm, wb, wr,
                    input logic [31:0] a);
    wr_q = wr;
    i_req_master.send('{1'b1, s, smm, wb, wr, 8'hFF, a}, rt);
  endtask
  task automatic hit(input logic [31:0] a, input target_t t);
    go(SRC_CPU, 1'b0, 1'b0, 1'b0, a);
    chk_route("window", t, a, 8'hFF);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs();
    cfg_read(LEGACY_CTRL_OFFSET);
    chk_byte("ctrl reset", LEGACY_CTRL_RESET, rd);
    cfg_write_read(LEGACY_CTRL_OFFSET, 8'h80);
    chk_byte("ctrl at once", 8'h80, rd);
    cfg_write(8'h10, 8'h55);
    cfg_read(8'h10);
    chk_byte("unmapped", 8'h00, rd);
    cfg_read(LEGACY_CTRL_OFFSET);
    chk_byte("ctrl", 8'h80, rd);
  endtask
  task automatic t_hole();
    hit(32'h00F0_0000, TGT_LINK);
    hit(32'h00FF_FFFF, TGT_LINK);
    hit(32'h00EF_FFFF, TGT_DRAM);
    hit(32'h0100_0000, TGT_DRAM);
    cfg_write(LEGACY_CTRL_OFFSET, 8'h00);
    hit(32'h00F0_0000, TGT_DRAM);
  endtask
  task automatic t_seg();
    // Reserved areas are sized before they are used
    seg_en = 1'b1;
    seg_size = SEG_2MB;
    go(SRC_CPU, 1'b0, 1'b0, 1'b0, 32'h0200_0000);
    chk_route("below seg", TGT_DRAM, 32'h0200_0000, 8'hFF);
    chk_mb("usable seg", 13'h003E, usable);
    gfx_en = 1'b1;
    gfx_size = GFX_1MB;
    seg_size = SEG_1MB;
    go(SRC_CPU, 1'b1, 1'b1, 1'b0, 32'h03E0_0040);
    chk_route("smm", TGT_DRAM, 32'h03E0_0040, 8'hFF);
    chk_mb("usable", 13'h003E, usable);
    go(SRC_LINK, 1'b0, 1'b0, 1'b1, 32'h03E0_1000);
    chk_route("link wr", TGT_INVALID, 32'h0, 8'h00);
    go(SRC_PCIE, 1'b0, 1'b0, 1'b0, 32'h03E0_1000);
    chk_route("pcie rd", TGT_INVALID, 32'h0, 8'hFF);
    go(SRC_GFX, 1'b1, 1'b1, 1'b1, 32'h03EF_FFFF);
    chk_route("gfx wr", TGT_INVALID, 32'h0, 8'h00);
    go(SRC_CPU, 1'b0, 1'b1, 1'b1, 32'h03E8_0000);
    chk_route("wb", TGT_DRAM, 32'h03E8_0000, 8'hFF);
    ext_en = 1'b1;
    go(SRC_CPU, 1'b1, 1'b0, 1'b0, 32'h03E0_0000);
    chk_route("ext", TGT_INVALID, 32'h0, 8'hFF);
    go(SRC_CPU, 1'b1, 1'b1, 1'b0, 32'h03E0_0000);
    chk_route("ext wb", TGT_DRAM, 32'h03E0_0000, 8'hFF);
    seg_size = SEG_8MB;
    go(SRC_CPU, 1'b0, 1'b0, 1'b0, 32'h0370_0000);
    chk_route("seg 8", TGT_INVALID, 32'h0, 8'hFF);
    hit(32'h036F_FFFF, TGT_DRAM);
    chk_mb("usable 8", 13'h0037, usable);
    ext_en = 1'b0;
  endtask
  task automatic t_gfx();
    logic [12:0] sz [6];
    logic [31:0] a;
    sz = '{13'h001, 13'h004, 13'h008, 13'h010, 13'h020, 13'h040};
    seg_en = 1'b0;
    top_mb = 13'h0100;
    for (int i = 0; i < 6; i++) begin
      gfx_size = 3'(i + 1);
      a = 32'({top_mb - sz[i], 20'h00000});
      go(SRC_CPU, 1'b0, 1'b1, 1'b0, a);
      chk_route("stolen cpu", TGT_INVALID, 32'h0, 8'hFF);
      go(SRC_GFX, 1'b0, 1'b0, 1'b0, a);
      chk_route("stolen gfx", TGT_DRAM, a, 8'hFF);
      chk_mb("usable gfx", top_mb - sz[i], usable);
    end
    top_mb = 13'h0040;
  endtask
  task automatic t_pci();
    // Windows kept clear of interrupt, APIC and BIOS areas
    win[WIN_EGRESS]   = '{1'b1, 32'h1000_0000, 32'h1000_0FFF};
    win[WIN_CTRL]     = '{1'b1, 32'h1000_4000, 32'h1000_7FFF};
    win[WIN_LINKREG]  = '{1'b1, 32'h1000_8000, 32'h1000_8FFF};
    win[WIN_PCIE_CFG] = '{1'b1, 32'h2000_0000, 32'h2FFF_FFFF};
    win[WIN_APER]     = '{1'b1, 32'h3000_0000, 32'h3FFF_FFFF};
    win[WIN_GTT]      = '{1'b1, 32'h4000_0000, 32'h400F_FFFF};
    win[WIN_GREG0]    = '{1'b1, 32'h4010_0000, 32'h4017_FFFF};
    win[WIN_GREG1]    = '{1'b1, 32'h4018_0000, 32'h401F_FFFF};
    win[WIN_PCIE_MEM] = '{1'b1, 32'h7000_0000, 32'h8FFF_FFFF};
    win[WIN_PCIE_PRE] = '{1'b1, 32'h6000_0000, 32'h6FFF_FFFF};
    pcie_en = 1'b1;
    hit(32'h0400_0000, TGT_LINK);
    hit(32'h1000_0000, TGT_INTERNAL);
    hit(32'h1000_4000, TGT_INTERNAL);
    hit(32'h1000_8FFF, TGT_INTERNAL);
    hit(32'h3000_0000, TGT_GFX);
    hit(32'h4000_0000, TGT_GFX);
    hit(32'h4010_0000, TGT_GFX);
    hit(32'h401F_FFFF, TGT_GFX);
    hit(32'h7000_0000, TGT_PCIE);
    hit(32'h7FFF_FFFF, TGT_PCIE);
    hit(32'h6000_0000, TGT_LINK);
    hit(32'h6000_0001, TGT_PCIE);
    hit(32'h6FFF_FFFF, TGT_LINK);
    hit(32'h8000_0000, TGT_LINK);
    hit(32'h5000_0000, TGT_LINK);
    hit(32'h2A5B_E000, TGT_PCIE_CFG);
    chk_byte("bus", 8'hA5, rt.bus);
    chk_byte("dev", 8'h17, {3'h0, rt.dev});
    chk_byte("func", 8'h06, {5'h00, rt.func});
    pcie_en = 1'b0;
    gfx_en = 1'b0;
    hit(32'h7000_0000, TGT_LINK);
    hit(32'h3000_0000, TGT_LINK);
  endtask
  // ==========================================================
  // Hang guard
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    n_fail++;
    end_sim();
  end
  // Main sequence
  initial begin
    repeat (4) @(negedge sys_clk_in);
    srst_in = 1'b0;
    t_regs();
    t_hole();
    t_seg();
    t_gfx();
    t_pci();
    end_sim();
  end
endmodule // memory_hole_smram_decode_bench
`default_nettype wire
